// ===== rtl/clw_comms_loss_watchdog.v
// Communications-loss watchdog with recovery, turnaround delay and APB registers.
//
// Notes on behaviour
// RULE_01: Clear policy 0 is manual, 1 automatic; reset value manual.
// RULE_02: Automatic mode waits a recovery delay after messages resume before clearing.
// RULE_03: Zero recovery delay clears the flag on the first valid message.
// RULE_04: Non-zero delay clears only if two messages arrive within the window.
// RULE_05: Flag reads 0 inactive, 1 active; set after inactivity exceeds timeout.
// RULE_06: Turnaround option inserts a pause between frame end and reply start.
// RULE_07: Turnaround pause applies only while the serial RTU protocol is selected.
// RULE_08: Resolution code 0 ms, 1 s, 2 min, 3 h scales time values.
// RULE_09: Timeout value is compared with time elapsed since last addressed.
// RULE_10: Over TCP every open connection must exceed the timeout.
// RULE_11: Turnaround length is a fixed parameterised cycle count.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "clw_defs.vh"
module clw_comms_loss_watchdog #(
    parameter MS_CYCLES   = `CLW_MS_CYCLES,
    parameter TURN_CYCLES = `CLW_TURN_CYCLES
) (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output wire        pready_out,
    output reg  [31:0] prdata_out,
    output reg         pslverr_out,
    input  wire [3:0]  conn_open_in,
    input  wire [3:0]  conn_msg_in,
    input  wire        rx_frame_end_in,
    input  wire        tx_request_in,
    output wire        tx_grant_out,
    output wire        comms_loss_flag_out,
    output wire [1:0]  time_value_resolution_out,
    output wire        irq_out
);
    localparam ST_OK      = 2'h0;
    localparam ST_LOST    = 2'h1;
    localparam ST_RECOVER = 2'h2;

    reg         loss_clear_policy;
    reg         turnaround_en;
    reg  [1:0]  protocol;
    reg  [1:0]  time_value_resolution;
    reg  [15:0] inactivity_timeout;
    reg  [15:0] loss_recovery_delay;
    reg  [1:0]  int_status;
    reg  [1:0]  int_mask;
    reg         comms_loss_flag;
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [15:0] win_timer;
    reg  [1:0]  win_msgs;
    reg  [16:0] elapsed [0:`CLW_CONNS-1];
    reg         expired_all_q;
    reg  [11:0] turn_hold;
    wire        unit_tick;
    wire [3:0]  conn_expired;
    wire        expired_all;
    wire        armed;
    wire        is_rtu;
    wire        is_tcp;
    wire        any_msg;
    wire        set_loss;
    wire        sw_clear;
    wire        win_end;
    reg         hw_clear;
    wire        wr_en;
    wire        rd_setup;

    function reg_hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            reg_hit = (addr == off);
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = reg_hit(addr, `CLW_OFF_CTRL) | reg_hit(addr, `CLW_OFF_TIMEOUT) |
                     reg_hit(addr, `CLW_OFF_RECOVERY) | reg_hit(addr, `CLW_OFF_FLAG) |
                     reg_hit(addr, `CLW_OFF_INT_STATUS) | reg_hit(addr, `CLW_OFF_INT_MASK);
        end
    endfunction

    assign wr_en    = psel_in & penable_in & pwrite_in;
    assign rd_setup = psel_in & ~penable_in;

    assign pready_out                = 1'b1;
    assign comms_loss_flag_out       = comms_loss_flag;
    assign time_value_resolution_out = time_value_resolution;
    assign irq_out                   = |(int_status & int_mask);

    assign is_rtu = (protocol == `CLW_PROTO_RTU);
    assign is_tcp = (protocol == `CLW_PROTO_TCP);
    assign armed  = (inactivity_timeout != 16'h0000) & (is_rtu | is_tcp);

    // Only connection 0 carries the serial link; TCP traffic may come on any.
    assign any_msg = is_rtu ? conn_msg_in[0] : (is_tcp & (|conn_msg_in));

    clw_unit_tick #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .res_in        (time_value_resolution),
        .unit_tick_out (unit_tick)
    );

    // Per-connection elapsed time since last addressed, in resolution units.
    genvar gi;
    generate
        for (gi = 0; gi < `CLW_CONNS; gi = gi + 1) begin : g_conn
            always @(posedge clk_in) begin
                if (!rst_n_in) begin
                    elapsed[gi] <= 17'h00000;
                end else if (conn_msg_in[gi]) begin
                    elapsed[gi] <= 17'h00000;
                end else if (unit_tick && elapsed[gi] != 17'h1FFFF) begin
                    elapsed[gi] <= elapsed[gi] + 17'h00001;
                end
            end
            if (gi == 0) begin : g_first
                assign conn_expired[gi] = (elapsed[gi] > {1'b0, inactivity_timeout}) | // [RULE_09]
                                          (is_tcp & ~conn_open_in[gi]);
            end else begin : g_rest
                assign conn_expired[gi] = (elapsed[gi] > {1'b0, inactivity_timeout}) |
                                          ~is_tcp | ~conn_open_in[gi]; // [RULE_10]
            end
        end
    endgenerate

    assign expired_all = armed & (&conn_expired); // [RULE_10]

    // The flag rises on the moment the last live connection runs out.
    assign set_loss = expired_all & ~expired_all_q; // [RULE_05]

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            expired_all_q <= 1'b1;
        end else begin
            expired_all_q <= expired_all;
        end
    end

    // Writing zero to the flag bit clears it; this is the manual path.
    assign sw_clear = wr_en & reg_hit(paddr_in, `CLW_OFF_FLAG) & ~pwdata_in[0]; // [RULE_01]

    assign win_end = unit_tick & (win_timer + 16'h0001 >= loss_recovery_delay);

    always @* begin
        next_state = state;
        hw_clear   = 1'b0;
        case (state)
            ST_OK: begin
                if (set_loss) begin
                    next_state = ST_LOST;
                end
            end
            ST_LOST: begin
                if (loss_clear_policy == `CLW_POLICY_AUTO && any_msg) begin // [RULE_01]
                    if (loss_recovery_delay == 16'h0000) begin
                        hw_clear   = 1'b1; // [RULE_03]
                        next_state = ST_OK;
                    end else begin
                        next_state = ST_RECOVER; // [RULE_02]
                    end
                end
            end
            ST_RECOVER: begin
                if (loss_clear_policy != `CLW_POLICY_AUTO) begin
                    next_state = ST_LOST;
                end else if (win_end) begin
                    if (win_msgs >= 2'h2 || (win_msgs == 2'h1 && any_msg)) begin
                        hw_clear   = 1'b1; // [RULE_04]
                        next_state = ST_OK;
                    end else begin
                        next_state = ST_LOST;
                    end
                end
            end
            default: begin
                next_state = ST_OK;
            end
        endcase
        if (set_loss) begin
            next_state = ST_LOST;
            hw_clear   = 1'b0;
        end else if (sw_clear) begin
            next_state = ST_OK;
        end
    end

    // Recovery window timer and message count.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state     <= ST_OK;
            win_timer <= 16'h0000;
            win_msgs  <= 2'h0;
        end else begin
            state <= next_state;
            if (state != ST_RECOVER) begin
                win_timer <= 16'h0000;
                win_msgs  <= any_msg ? 2'h1 : 2'h0;
            end else begin
                if (unit_tick) begin
                    win_timer <= win_timer + 16'h0001; // [RULE_02]
                end
                if (any_msg && win_msgs != 2'h2) begin
                    win_msgs <= win_msgs + 2'h1; // [RULE_04]
                end
            end
        end
    end

    // Set wins over either clear in the same cycle.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            comms_loss_flag <= 1'b0;
        end else if (set_loss) begin
            comms_loss_flag <= 1'b1; // [RULE_05]
        end else if (sw_clear || hw_clear) begin
            comms_loss_flag <= 1'b0;
        end
    end

    // Turnaround hold-off after a received frame, serial RTU only.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            turn_hold <= 12'h000;
        end else if (rx_frame_end_in && turnaround_en && is_rtu) begin // [RULE_07]
            turn_hold <= TURN_CYCLES[11:0]; // [RULE_11]
        end else if (turn_hold != 12'h000) begin
            turn_hold <= turn_hold - 12'h001;
        end
    end

    assign tx_grant_out = tx_request_in & (turn_hold == 12'h000); // [RULE_06]

    // Configuration registers.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            loss_clear_policy     <= `CLW_POLICY_MANUAL; // [RULE_01]
            turnaround_en         <= 1'b0;
            protocol              <= `CLW_PROTO_NONE;
            time_value_resolution <= `CLW_RES_MSEC; // [RULE_08]
            inactivity_timeout    <= `CLW_RST_TIMEOUT;
            loss_recovery_delay   <= `CLW_RST_RECOVERY;
            int_mask              <= 2'h0;
        end else if (wr_en) begin
            if (reg_hit(paddr_in, `CLW_OFF_CTRL)) begin
                loss_clear_policy     <= pwdata_in[`CLW_CTRL_POLICY];
                turnaround_en         <= pwdata_in[`CLW_CTRL_TURN_EN];
                protocol              <= pwdata_in[`CLW_CTRL_PROTO_HI:`CLW_CTRL_PROTO_LO];
                time_value_resolution <= pwdata_in[`CLW_CTRL_RES_HI:`CLW_CTRL_RES_LO];
            end
            if (reg_hit(paddr_in, `CLW_OFF_TIMEOUT)) begin
                inactivity_timeout <= pwdata_in[15:0];
            end
            if (reg_hit(paddr_in, `CLW_OFF_RECOVERY)) begin
                loss_recovery_delay <= pwdata_in[15:0];
            end
            if (reg_hit(paddr_in, `CLW_OFF_INT_MASK)) begin
                int_mask <= pwdata_in[1:0];
            end
        end
    end

    // Sticky event bits, write one to clear, set wins.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            int_status <= 2'h0;
        end else begin
            if (set_loss) begin
                int_status[`CLW_INT_RAISED] <= 1'b1;
            end else if (wr_en && reg_hit(paddr_in, `CLW_OFF_INT_STATUS) &&
                         pwdata_in[`CLW_INT_RAISED]) begin
                int_status[`CLW_INT_RAISED] <= 1'b0;
            end
            if (comms_loss_flag && !set_loss && (sw_clear || hw_clear)) begin
                int_status[`CLW_INT_CLEARED] <= 1'b1;
            end else if (wr_en && reg_hit(paddr_in, `CLW_OFF_INT_STATUS) &&
                         pwdata_in[`CLW_INT_CLEARED]) begin
                int_status[`CLW_INT_CLEARED] <= 1'b0;
            end
        end
    end

    // Read data and error are captured in the setup cycle.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            prdata_out  <= 32'h00000000;
            pslverr_out <= 1'b0;
        end else if (rd_setup) begin
            pslverr_out <= ~mapped(paddr_in);
            prdata_out  <= 32'h00000000;
            if (reg_hit(paddr_in, `CLW_OFF_CTRL) && !pwrite_in) begin
                prdata_out <= {26'h0000000, time_value_resolution, protocol,
                               turnaround_en, loss_clear_policy};
            end
            if (reg_hit(paddr_in, `CLW_OFF_TIMEOUT) && !pwrite_in) begin
                prdata_out <= {16'h0000, inactivity_timeout};
            end
            if (reg_hit(paddr_in, `CLW_OFF_RECOVERY) && !pwrite_in) begin
                prdata_out <= {16'h0000, loss_recovery_delay};
            end
            if (reg_hit(paddr_in, `CLW_OFF_FLAG) && !pwrite_in) begin
                prdata_out <= {29'h00000000, state, comms_loss_flag}; // [RULE_05]
            end
            if (reg_hit(paddr_in, `CLW_OFF_INT_STATUS) && !pwrite_in) begin
                prdata_out <= {30'h00000000, int_status};
            end
            if (reg_hit(paddr_in, `CLW_OFF_INT_MASK) && !pwrite_in) begin
                prdata_out <= {30'h00000000, int_mask};
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/clw_defs.vh
// Offsets, field positions, reset values, codes and timing counts of the watchdog.
`ifndef CLW_DEFS_VH
`define CLW_DEFS_VH

`define CLW_CLK_PERIOD_PS   5000
`define CLW_MS_TIME_PS      1000000000
`define CLW_MS_CYCLES       (`CLW_MS_TIME_PS / `CLW_CLK_PERIOD_PS)
`define CLW_TURN_TIME_NS    10000
`define CLW_TURN_CYCLES     ((`CLW_TURN_TIME_NS * 1000 + `CLW_CLK_PERIOD_PS - 1) / `CLW_CLK_PERIOD_PS)

`define CLW_OFF_CTRL        8'h00
`define CLW_OFF_TIMEOUT     8'h04
`define CLW_OFF_RECOVERY    8'h08
`define CLW_OFF_FLAG        8'h0C
`define CLW_OFF_INT_STATUS  8'h10
`define CLW_OFF_INT_MASK    8'h14

`define CLW_CTRL_POLICY     0
`define CLW_CTRL_TURN_EN    1
`define CLW_CTRL_PROTO_LO   2
`define CLW_CTRL_PROTO_HI   3
`define CLW_CTRL_RES_LO     4
`define CLW_CTRL_RES_HI     5

`define CLW_INT_RAISED      0
`define CLW_INT_CLEARED     1

`define CLW_POLICY_MANUAL   1'h0
`define CLW_POLICY_AUTO     1'h1
`define CLW_PROTO_NONE      2'h0
`define CLW_PROTO_RTU       2'h1
`define CLW_PROTO_TCP       2'h2
`define CLW_RES_MSEC        2'h0
`define CLW_RES_SEC         2'h1
`define CLW_RES_MIN         2'h2
`define CLW_RES_HOUR        2'h3

`define CLW_UNIT_MS_MSEC    22'h000001
`define CLW_UNIT_MS_SEC     22'h0003E8
`define CLW_UNIT_MS_MIN     22'h00EA60
`define CLW_UNIT_MS_HOUR    22'h36EE80

`define CLW_CONNS           4
`define CLW_RST_TIMEOUT     16'h0000
`define CLW_RST_RECOVERY    16'h0000

`endif

// ===== rtl/clw_unit_tick.v
// Pulse generator that marks one period of the selected time resolution.
`timescale 1ns/1ps
`default_nettype none
`include "clw_defs.vh"
module clw_unit_tick #(
    parameter MS_CYCLES = `CLW_MS_CYCLES
) (
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire [1:0] res_in,
    output reg        unit_tick_out
);
    reg  [17:0] ms_cnt;
    reg  [21:0] unit_cnt;
    reg  [1:0]  res_q;
    wire        ms_tick;

    function [21:0] unit_ms;
        input [1:0] res;
        begin
            case (res)
                `CLW_RES_MSEC: unit_ms = `CLW_UNIT_MS_MSEC;
                `CLW_RES_SEC:  unit_ms = `CLW_UNIT_MS_SEC;
                `CLW_RES_MIN:  unit_ms = `CLW_UNIT_MS_MIN;
                default:       unit_ms = `CLW_UNIT_MS_HOUR;
            endcase
        end
    endfunction

    assign ms_tick = (ms_cnt == MS_CYCLES[17:0] - 18'h00001);

    // Millisecond prescaler, then a count of milliseconds per unit.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            ms_cnt        <= 18'h00000;
            unit_cnt      <= 22'h000000;
            res_q         <= `CLW_RES_MSEC;
            unit_tick_out <= 1'b0;
        end else begin
            res_q         <= res_in;
            unit_tick_out <= 1'b0;
            if (res_q != res_in) begin
                ms_cnt   <= 18'h00000;
                unit_cnt <= 22'h000000;
            end else if (ms_tick) begin
                ms_cnt <= 18'h00000;
                if (unit_cnt == unit_ms(res_q) - 22'h000001) begin // [RULE_08]
                    unit_cnt      <= 22'h000000;
                    unit_tick_out <= 1'b1;
                end else begin
                    unit_cnt <= unit_cnt + 22'h000001;
                end
            end else begin
                ms_cnt <= ms_cnt + 18'h00001;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/clw_remote_master.sv
// Remote master model: addresses the device and asks for replies.
`timescale 1ns/1ps
`default_nettype none
module clw_remote_master (
    input wire logic  clk_in,
    output logic [3:0] conn_open_out,
    output logic [3:0] conn_msg_out,
    output logic       frame_end_out,
    output logic       tx_req_out,
    input wire logic  tx_grant_in
);
    initial begin
        conn_open_out = 4'h0;
        conn_msg_out  = 4'h0;
        frame_end_out = 1'b0;
        tx_req_out    = 1'b0;
    end
    task automatic open_conns(input logic [3:0] m);
        @(posedge clk_in);
        conn_open_out <= m;
    endtask
    task automatic send(input logic [3:0] m);
        @(posedge clk_in);
        conn_msg_out <= m;
        @(posedge clk_in);
        conn_msg_out <= 4'h0;
    endtask
    task automatic frame(output int waited);
        @(posedge clk_in);
        frame_end_out <= 1'b1;
        tx_req_out    <= 1'b1;
        @(posedge clk_in);
        frame_end_out <= 1'b0;
        waited = 0;
        @(negedge clk_in);
        while (tx_grant_in !== 1'b1 && waited < 100) begin
            waited++;
            @(negedge clk_in);
        end
        @(posedge clk_in);
        tx_req_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/clw_watchdog_asserts.sv
// Concurrent checks on the ports of the comms-loss watchdog.
`timescale 1ns/1ps
`default_nettype none
module clw_watchdog_asserts #(
    parameter TURN_CYCLES = 2000
) (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic [3:0]  conn_msg_in,
    input wire logic        rx_frame_end_in,
    input wire logic        tx_request_in,
    input wire logic        tx_grant_out,
    input wire logic        comms_loss_flag_out,
    input wire logic [1:0]  time_value_resolution_out
);
    logic [5:0]  ctl;
    logic        rec0;
    logic [15:0] q;
    wire         wr  = psel_in & penable_in & pwrite_in;
    wire         rtu = ctl[3:2] == 2'h1;
    wire         en  = ctl[1] & rtu;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctl  <= 6'h00;
            rec0 <= 1'b1;
            q    <= 16'hFFFF;
        end else begin
            if (wr && paddr_in == 8'h00) begin
                ctl <= pwdata_in[5:0];
            end
            if (wr && paddr_in == 8'h08) begin
                rec0 <= pwdata_in[15:0] == 16'h0000;
            end
            if (rx_frame_end_in && en) begin
                q <= 16'h0001;
            end else if (q != 16'hFFFF) begin
                q <= q + 16'h0001;
            end
        end
    end
    a_apb_ready: assert property (psel_in && penable_in |-> pready_out)
        else $error("pready low in access phase");
    a_grant_needs_req: assert property (tx_grant_out |-> tx_request_in)
        else $error("grant without request");
    a_turn_hold: assert property (q >= 1 && q <= TURN_CYCLES |-> !tx_grant_out)
        else $error("grant during turnaround pause");
    a_turn_release: assert property (q > TURN_CYCLES |-> tx_grant_out == tx_request_in)
        else $error("pause longer than its count");
    a_turn_rtu_only: assert property (rx_frame_end_in && !en && q > TURN_CYCLES
        |=> tx_grant_out == tx_request_in)
        else $error("pause outside serial mode");
    a_manual_keep: assert property (comms_loss_flag_out && !ctl[0]
        && !(wr && paddr_in == 8'h0C) |=> comms_loss_flag_out)
        else $error("flag cleared without software in manual");
    a_rec0_clear: assert property (comms_loss_flag_out && ctl[0] && rec0 && rtu
        && conn_msg_in[0] && !wr |=> !comms_loss_flag_out)
        else $error("flag kept after first message");
    a_rise_quiet: assert property ($rose(comms_loss_flag_out) && rtu
        |-> !$past(conn_msg_in[0]))
        else $error("flag raised right after a message");
    a_res_follow: assert property (wr && paddr_in == 8'h00
        |=> time_value_resolution_out == $past(pwdata_in[5:4]))
        else $error("resolution output not updated");
endmodule
bind clw_comms_loss_watchdog clw_watchdog_asserts #(.TURN_CYCLES(TURN_CYCLES)) i_chk (
    .clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pready_out, .conn_msg_in, .rx_frame_end_in, .tx_request_in, .tx_grant_out,
    .comms_loss_flag_out, .time_value_resolution_out
);
`default_nettype wire

// ===== tb/tb_comms_loss_watchdog.sv
// Self-checking bench for the comms-loss watchdog.
`timescale 1ns/1ps
`default_nettype none
`include "clw_defs.vh"
module tb_comms_loss_watchdog;
    localparam int MS   = 4;
    localparam int TURN = 8;
    logic        clk_in   = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [3:0]  open;
    logic [3:0]  msg;
    logic [1:0]  res;
    logic        pready, pslverr, grant, flag, irq, fend, treq, err;
    int          mismatches = 0;
    int          n_compared = 0;
    int          tmo, rec, n;
    int          exp_q[$];
    int          ctls[3] = '{32'h6, 32'hA, 32'h4};
    always #2.5 clk_in = ~clk_in;
    clw_comms_loss_watchdog #(.MS_CYCLES(MS), .TURN_CYCLES(TURN)) i_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(pslverr), .conn_open_in(open), .conn_msg_in(msg),
        .rx_frame_end_in(fend), .tx_request_in(treq), .tx_grant_out(grant),
        .comms_loss_flag_out(flag), .time_value_resolution_out(res), .irq_out(irq)
    );
    clw_remote_master i_master (
        .clk_in(clk_in), .conn_open_out(open), .conn_msg_out(msg),
        .frame_end_out(fend), .tx_req_out(treq), .tx_grant_in(grant)
    );
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) begin
            @(posedge clk_in);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge clk_in);
    endtask
    task automatic wait_flag(input string nm, input logic v, input int lo, input int hi);
        int c;
        c = 0;
        while (flag !== v && c < hi + 20) begin
            @(negedge clk_in);
            c++;
        end
        chk_rng(nm, lo, hi, c);
    endtask
    task automatic expire();
        i_master.send(4'h1);
        apb(1'b1, `CLW_OFF_FLAG, 32'h0);
        wait_flag("raise", 1'b1, tmo * MS - 6, (tmo + 1) * MS + 3);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        print_verdict();
    end
    initial begin
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
        paddr   <= 8'h00;
        pwdata  <= 32'h00000000;
        void'($urandom(32'hE36AF837));
        tmo = 6 + $urandom % 4;
        rec = 2 + $urandom % 2;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int a = 0; a <= 24; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            chk("reset read", 32'h0, rd);
            chk("slverr", a == 24, err);
        end
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, `CLW_OFF_CTRL, r << 4);
            chk("resolution", r, res);
        end
        $display("test reset and resolution done");
        apb(1'b1, `CLW_OFF_INT_MASK, 32'h1);
        apb(1'b1, `CLW_OFF_TIMEOUT, tmo);
        apb(1'b0, `CLW_OFF_TIMEOUT, 32'h0);
        chk("timeout", tmo, rd);
        apb(1'b1, `CLW_OFF_CTRL, 32'h4);
        expire();
        chk("irq", 1'b1, irq);
        apb(1'b0, `CLW_OFF_FLAG, 32'h0);
        chk("flag reg", 32'h3, rd);
        i_master.send(4'h1);
        i_master.send(4'h1);
        chk("manual hold", 1'b1, flag);
        apb(1'b1, `CLW_OFF_INT_MASK, 32'h0);
        chk("irq masked", 1'b0, irq);
        apb(1'b1, `CLW_OFF_FLAG, 32'h0);
        chk("manual clear", 1'b0, flag);
        apb(1'b1, `CLW_OFF_INT_STATUS, 32'h3);
        apb(1'b1, `CLW_OFF_INT_MASK, 32'h3);
        chk("irq cleared", 1'b0, irq);
        $display("test manual done");
        apb(1'b1, `CLW_OFF_CTRL, 32'h5);
        expire();
        apb(1'b1, `CLW_OFF_INT_STATUS, 32'h3);
        i_master.send(4'h1);
        wait_flag("first msg clear", 1'b0, 0, 2);
        apb(1'b0, `CLW_OFF_INT_STATUS, 32'h0);
        chk("cleared event", 32'h2, rd);
        apb(1'b1, `CLW_OFF_RECOVERY, rec);
        expire();
        i_master.send(4'h1);
        repeat ((rec + 2) * MS) @(negedge clk_in);
        chk("single msg", 1'b1, flag);
        i_master.send(4'h1);
        i_master.send(4'h1);
        wait_flag("recovery", 1'b0, (rec - 1) * MS - 2, (rec + 1) * MS + 4);
        $display("test auto done");
        i_master.open_conns(4'h3);
        apb(1'b1, `CLW_OFF_CTRL, 32'h8);
        repeat (4) begin
            i_master.send(4'h1);
            repeat ((tmo - 1) * MS) @(negedge clk_in);
        end
        chk("one link alive", 1'b0, flag);
        expire();
        $display("test tcp done");
        exp_q = '{TURN, 0, 0};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `CLW_OFF_CTRL, ctls[i]);
            i_master.frame(n);
            chk("turnaround", exp_q.pop_front(), n);
        end
        $display("test turnaround done");
        print_verdict();
    end
endmodule
`default_nettype wire
